// ### hdl/cpu_decode_pkg.sv
// Shared constants, types and layouts for the operand and bank decode core.
// Assumes one 25 MHz clock and program memory on that same clock.
//
// Notes on behaviour
// [RULE1] Operand code 00..11 picks accumulator, work, mem one, mem two.
// [RULE2] Index registers are 12 bits: page nibble over a byte of two nibbles.
// [RULE3] Stack pointer is 8 bits, nibble writable, addresses stack operands.
// [RULE4] Direct operands use a 4-bit value, reaching only 000H-00FH.
// [RULE5] Program counter is bank, page and 8-bit step with two step nibbles.
// [RULE6] Flags: interrupt enable, decimal, zero, carry; each set or cleared.
// [RULE7] Add and subtract adjust to decimal while the decimal flag is set.
// [RULE8] Preset operand is five bits, 00H-1FH.
// [RULE9] Eight-bit operands span 00H-0FFH; four-bit data spans 00H-0FH.
// [RULE10] Preset loads pending bank from bit 4, page from 3-0, in 5 clocks.
// [RULE11] Every instruction is exactly one 12-bit word.
// [RULE12] Jump loads pending bank, page and step; carry-clear form needs C=0.
// [RULE13] Without a preset just before, pending equals current bank and page.
package cpu_decode_pkg;

  localparam int INSTR_W = 12;
  localparam int DMEM_AW = 12;
  localparam int CLK_PER_INSTR = 5;
  localparam int CNT_W = 3;
  // Counter load on entry to execute; the state lasts this many cycles plus one before commit.
  localparam logic [2:0] EXEC_LOAD = 3'(CLK_PER_INSTR - 3);

  // Field positions inside the instruction word.
  localparam int OPC_HI = 11;
  localparam int OPC_LO = 8;
  localparam int PRE_HI = 11;
  localparam int PRE_LO = 5;
  localparam int PRE_BANK_BIT = 4;
  localparam int FLD_R_HI = 3;
  localparam int FLD_R_LO = 2;
  localparam int FLD_Q_HI = 1;
  localparam int FLD_Q_LO = 0;

  // Opcode patterns.
  localparam logic [3:0] OPC_JUMP = 4'h0;
  localparam logic [3:0] OPC_JUMP_C = 4'h2;
  localparam logic [3:0] OPC_JUMP_NC = 4'h3;
  localparam logic [6:0] OPC_PRESET = 7'h72;

  // Reset values.
  localparam logic RST_BANK = 1'b0;
  localparam logic [3:0] RST_PAGE = 4'h0;
  localparam logic [7:0] RST_STEP = 8'h00;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [11:0] RST_INSTR = 12'h000;

  // Decimal adjust constants.
  localparam logic [4:0] DEC_MAX = 5'h09;
  localparam logic [4:0] DEC_ADJ = 5'h06;
  localparam logic [4:0] BIN_MAX = 5'h0f;

  typedef enum logic [1:0] {
    SEL_ACC = 2'b00,
    SEL_WORK = 2'b01,
    SEL_MEM_ONE = 2'b10,
    SEL_MEM_TWO = 2'b11
  } operand_sel_t;

  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_ONE_PAGE = 4'h1,
    TGT_ONE_MID = 4'h2,
    TGT_ONE_LOW = 4'h3,
    TGT_TWO_PAGE = 4'h4,
    TGT_TWO_MID = 4'h5,
    TGT_TWO_LOW = 4'h6,
    TGT_SP_HIGH = 4'h7,
    TGT_SP_LOW = 4'h8
  } nibble_tgt_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_COMMIT = 2'b11
  } core_state_t;

  typedef struct packed {
    logic [3:0] page;
    logic [7:0] low_byte;
  } index_t;

  typedef struct packed {
    logic irq_en;
    logic decimal;
    logic zero;
    logic carry;
  } flags_t;

  typedef struct packed {
    logic bank;
    logic [3:0] page;
    logic [7:0] step;
  } pc_t;

  typedef struct packed {
    operand_sel_t sel;
    logic [11:0] addr;
  } operand_t;

endpackage

// ### hdl/nibble_pair_reg.sv
// Eight-bit register whose two nibbles are written on their own.
// Assumes a synchronised active-low reset from the parent.
`timescale 1ns/10ps
module nibble_pair_reg (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Nibble writes.
  input wire logic wr_high,
  input wire logic wr_low,
  input wire logic [3:0] din,
  // Stored byte.
  output logic [7:0] q
);

  logic [7:0] q_r;
  logic [7:0] q_nxt;

  // Each half takes the shared data only when its own strobe is up.
  always_comb begin
    q_nxt = q_r;
    if (wr_high) begin
      q_nxt[7:4] = din;
    end
    if (wr_low) begin
      q_nxt[3:0] = din;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q_r <= {cpu_decode_pkg::RST_NIBBLE, cpu_decode_pkg::RST_NIBBLE};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

// ### hdl/cpu_operand_and_bank_set_decode.sv
// Operand decode, pointer registers, flags and bank/page branch logic.
// Assumes program memory on clk_sys answers each fetch address with a word.
`timescale 1ns/10ps
module cpu_operand_and_bank_set_decode (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic nrst,
  // Instruction fetch.
  output cpu_decode_pkg::pc_t instr_addr,
  input wire logic [11:0] instr_word,
  input wire logic instr_valid,
  output logic instr_ready,
  output logic instr_done,
  // Nibble register writes from the datapath.
  input wire logic wr_en,
  input wire cpu_decode_pkg::nibble_tgt_t wr_tgt,
  input wire logic [3:0] wr_data,
  // Flag control.
  input wire logic [3:0] flag_set,
  input wire logic [3:0] flag_clr,
  // Arithmetic request.
  input wire logic alu_go,
  input wire logic alu_sub,
  input wire logic alu_use_carry,
  input wire logic [3:0] alu_a,
  input wire logic [3:0] alu_b,
  output logic [3:0] alu_res,
  // Register views.
  output cpu_decode_pkg::index_t index_ptr_one,
  output cpu_decode_pkg::index_t index_ptr_two,
  output logic [7:0] stack_ptr,
  output cpu_decode_pkg::flags_t flags,
  output logic pending_bank,
  output logic [3:0] pending_page,
  output logic [3:0] pc_step_high,
  output logic [3:0] pc_step_low,
  // Decoded operands.
  output cpu_decode_pkg::operand_t operand_r,
  output cpu_decode_pkg::operand_t operand_q,
  output logic [11:0] direct_addr,
  output logic [11:0] stack_addr
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release.

  logic rst_meta_r;
  logic rst_n;

  // Assert at once, release through two flops so no flop sees a ragged edge.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: every word takes the same fixed number of clocks.

  cpu_decode_pkg::core_state_t state_r;
  cpu_decode_pkg::core_state_t state_nxt;
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic [11:0] instr_r;
  logic [11:0] instr_nxt;
  logic take;
  logic commit;

  assign instr_ready = (state_r == cpu_decode_pkg::ST_IDLE);
  assign take = instr_valid && instr_ready;
  assign commit = (state_r == cpu_decode_pkg::ST_COMMIT);
  assign instr_done = commit;

  // One whole word is latched per fetch; no partial words exist. 
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    instr_nxt = instr_r;
    case (state_r)
      cpu_decode_pkg::ST_IDLE: begin
        if (instr_valid) begin
          instr_nxt = instr_word; // RULE11
          cnt_nxt = cpu_decode_pkg::EXEC_LOAD; // RULE10
          state_nxt = cpu_decode_pkg::ST_EXEC;
        end
      end
      cpu_decode_pkg::ST_EXEC: begin
        if (cnt_r == 3'h0) begin
          state_nxt = cpu_decode_pkg::ST_COMMIT;
        end else begin
          cnt_nxt = cnt_r - 3'h1;
        end
      end
      cpu_decode_pkg::ST_COMMIT: begin
        state_nxt = cpu_decode_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = cpu_decode_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= cpu_decode_pkg::ST_IDLE;
      cnt_r <= 3'h0;
      instr_r <= cpu_decode_pkg::RST_INSTR;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      instr_r <= instr_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Program counter and pending bank/page.

  logic [3:0] opc;
  logic is_preset;
  logic jump_taken;
  cpu_decode_pkg::pc_t pc_r;
  cpu_decode_pkg::pc_t pc_nxt;
  logic pend_bank_r;
  logic pend_bank_nxt;
  logic [3:0] pend_page_r;
  logic [3:0] pend_page_nxt;
  cpu_decode_pkg::flags_t flags_r;
  cpu_decode_pkg::flags_t flags_nxt;

  assign opc = instr_r[cpu_decode_pkg::OPC_HI:cpu_decode_pkg::OPC_LO];
  assign is_preset = (instr_r[cpu_decode_pkg::PRE_HI:cpu_decode_pkg::PRE_LO]
                      == cpu_decode_pkg::OPC_PRESET);
  // The carry-set form also jumps, on carry set.
  assign jump_taken = (opc == cpu_decode_pkg::OPC_JUMP)
                      || (opc == cpu_decode_pkg::OPC_JUMP_C && flags_r.carry)
                      || (opc == cpu_decode_pkg::OPC_JUMP_NC
                          && !flags_r.carry); // RULE12

  // Commit moves the counter; any word but a preset re-aims pending at the
  // counter, so a lone jump stays in the page it was fetched from.
  always_comb begin
    pc_nxt = pc_r;
    pend_bank_nxt = pend_bank_r;
    pend_page_nxt = pend_page_r;
    if (commit) begin
      if (jump_taken) begin
        pc_nxt.bank = pend_bank_r; // RULE12
        pc_nxt.page = pend_page_r; // RULE12
        pc_nxt.step = instr_r[7:0]; // RULE9
      end else begin
        pc_nxt.step = pc_r.step + 8'h01; // RULE5
      end
      if (is_preset) begin
        pend_bank_nxt = instr_r[cpu_decode_pkg::PRE_BANK_BIT]; // RULE10
        pend_page_nxt = instr_r[3:0]; // RULE8
      end else begin
        pend_bank_nxt = pc_nxt.bank; // RULE13
        pend_page_nxt = pc_nxt.page; // RULE13
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pc_r <= {cpu_decode_pkg::RST_BANK, cpu_decode_pkg::RST_PAGE,
               cpu_decode_pkg::RST_STEP};
      pend_bank_r <= cpu_decode_pkg::RST_BANK;
      pend_page_r <= cpu_decode_pkg::RST_PAGE;
    end else begin
      pc_r <= pc_nxt;
      pend_bank_r <= pend_bank_nxt;
      pend_page_r <= pend_page_nxt;
    end
  end

  assign instr_addr = pc_r;
  assign pending_bank = pend_bank_r;
  assign pending_page = pend_page_r;
  assign pc_step_high = pc_r.step[7:4]; // RULE5
  assign pc_step_low = pc_r.step[3:0]; // RULE5

  ////////////////////////////////////////////////////////////////////////////
  // Flags and the nibble adder.

  logic [4:0] raw;
  logic [4:0] adj;
  logic cin;
  logic cout;
  logic [3:0] alu_res_r;
  logic [3:0] alu_res_nxt;

  // Decimal mode adds six past nine, or takes six off after a borrow; the
  // adjust is only meaningful for operands already in 0..9.
  always_comb begin
    cin = alu_use_carry && flags_r.carry;
    if (alu_sub) begin
      raw = {1'b0, alu_a} - {1'b0, alu_b} - {4'h0, cin};
      cout = raw[4];
      adj = (flags_r.decimal && cout) ? raw - cpu_decode_pkg::DEC_ADJ
                                      : raw; // RULE7
    end else begin
      raw = {1'b0, alu_a} + {1'b0, alu_b} + {4'h0, cin};
      cout = flags_r.decimal ? (raw > cpu_decode_pkg::DEC_MAX)
                             : (raw > cpu_decode_pkg::BIN_MAX); // RULE7
      adj = (flags_r.decimal && cout) ? raw + cpu_decode_pkg::DEC_ADJ
                                      : raw; // RULE7
    end
    alu_res_nxt = alu_go ? adj[3:0] : alu_res_r;
  end

  // Explicit set beats clear, and both beat an adder update of Z and C.
  always_comb begin
    flags_nxt = flags_r;
    if (alu_go) begin
      flags_nxt.carry = cout;
      flags_nxt.zero = (adj[3:0] == 4'h0);
    end
    flags_nxt = (flags_nxt & ~flag_clr) | flag_set; // RULE6
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= cpu_decode_pkg::RST_FLAGS;
      alu_res_r <= cpu_decode_pkg::RST_NIBBLE;
    end else begin
      flags_r <= flags_nxt;
      alu_res_r <= alu_res_nxt;
    end
  end

  assign flags = flags_r;
  assign alu_res = alu_res_r;

  ////////////////////////////////////////////////////////////////////////////
  // Index registers and stack pointer.

  logic [3:0] one_page_r;
  logic [3:0] one_page_nxt;
  logic [3:0] two_page_r;
  logic [3:0] two_page_nxt;
  logic [7:0] one_byte;
  logic [7:0] two_byte;
  logic [7:0] sp_byte;

  always_comb begin
    one_page_nxt = one_page_r;
    two_page_nxt = two_page_r;
    if (wr_en && wr_tgt == cpu_decode_pkg::TGT_ONE_PAGE) begin
      one_page_nxt = wr_data; // RULE2
    end
    if (wr_en && wr_tgt == cpu_decode_pkg::TGT_TWO_PAGE) begin
      two_page_nxt = wr_data; // RULE2
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      one_page_r <= cpu_decode_pkg::RST_NIBBLE;
      two_page_r <= cpu_decode_pkg::RST_NIBBLE;
    end else begin
      one_page_r <= one_page_nxt;
      two_page_r <= two_page_nxt;
    end
  end

  // The low bytes and the stack pointer are nibble-addressable halves.
  nibble_pair_reg u_one_byte (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_high(wr_en && wr_tgt == cpu_decode_pkg::TGT_ONE_MID), // RULE2
    .wr_low(wr_en && wr_tgt == cpu_decode_pkg::TGT_ONE_LOW),
    .din(wr_data),
    .q(one_byte)
  );

  nibble_pair_reg u_two_byte (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_high(wr_en && wr_tgt == cpu_decode_pkg::TGT_TWO_MID), // RULE2
    .wr_low(wr_en && wr_tgt == cpu_decode_pkg::TGT_TWO_LOW),
    .din(wr_data),
    .q(two_byte)
  );

  nibble_pair_reg u_stack (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .wr_high(wr_en && wr_tgt == cpu_decode_pkg::TGT_SP_HIGH), // RULE3
    .wr_low(wr_en && wr_tgt == cpu_decode_pkg::TGT_SP_LOW),
    .din(wr_data),
    .q(sp_byte)
  );

  assign index_ptr_one = {one_page_r, one_byte};
  assign index_ptr_two = {two_page_r, two_byte};
  assign stack_ptr = sp_byte;

  ////////////////////////////////////////////////////////////////////////////
  // Operand decode, registered so the outputs come straight from flops.

  cpu_decode_pkg::operand_t op_r_r;
  cpu_decode_pkg::operand_t op_r_nxt;
  cpu_decode_pkg::operand_t op_q_r;
  cpu_decode_pkg::operand_t op_q_nxt;
  logic [11:0] direct_r;
  logic [11:0] direct_nxt;
  logic [11:0] stack_r;
  logic [11:0] stack_nxt;

  function automatic cpu_decode_pkg::operand_t decode_field(
    input logic [1:0] code,
    input cpu_decode_pkg::index_t one,
    input cpu_decode_pkg::index_t two
  );
    cpu_decode_pkg::operand_t res;
    res.sel = cpu_decode_pkg::operand_sel_t'(code); // RULE1
    case (code)
      2'b10: res.addr = one; // RULE1
      2'b11: res.addr = two; // RULE1
      default: res.addr = 12'h000;
    endcase
    return res;
  endfunction

  always_comb begin
    op_r_nxt = decode_field(
      instr_r[cpu_decode_pkg::FLD_R_HI:cpu_decode_pkg::FLD_R_LO],
      index_ptr_one, index_ptr_two);
    op_q_nxt = decode_field(
      instr_r[cpu_decode_pkg::FLD_Q_HI:cpu_decode_pkg::FLD_Q_LO],
      index_ptr_one, index_ptr_two);
    direct_nxt = {8'h00, instr_r[3:0]}; // RULE4
    stack_nxt = {4'h0, sp_byte}; // RULE3
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_r_r <= '0;
      op_q_r <= '0;
      direct_r <= 12'h000;
      stack_r <= 12'h000;
    end else begin
      op_r_r <= op_r_nxt;
      op_q_r <= op_q_nxt;
      direct_r <= direct_nxt;
      stack_r <= stack_nxt;
    end
  end

  assign operand_r = op_r_r;
  assign operand_q = op_q_r;
  assign direct_addr = direct_r;
  assign stack_addr = stack_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_busy;
    !instr_ready [*4];
  endsequence
  property p_fixed_len;
    take |=> s_busy ##1 instr_ready;
  endproperty
  a_fixed_len: assert property (p_fixed_len) // RULE10
    else $error("word did not take five clocks");

  property p_preset_load;
    commit && is_preset |=> pending_bank == $past(instr_r[4])
      && pending_page == $past(instr_r[3:0]);
  endproperty
  a_preset_load: assert property (p_preset_load) // RULE10
    else $error("preset did not load pending bank and page");

  property p_jump_load;
    commit && jump_taken |=> instr_addr.bank == $past(pend_bank_r)
      && instr_addr.page == $past(pend_page_r)
      && instr_addr.step == $past(instr_r[7:0]);
  endproperty
  a_jump_load: assert property (p_jump_load) // RULE12
    else $error("taken jump loaded the wrong counter value");

  property p_nc_blocked;
    commit && opc == cpu_decode_pkg::OPC_JUMP_NC && flags_r.carry
      |=> instr_addr.step == $past(pc_r.step) + 8'h01;
  endproperty
  a_nc_blocked: assert property (p_nc_blocked) // RULE12
    else $error("carry-clear jump taken with carry set");

  property p_pending_follow;
    commit && !is_preset |=> pending_bank == instr_addr.bank
      && pending_page == instr_addr.page;
  endproperty
  a_pending_follow: assert property (p_pending_follow) // RULE13
    else $error("pending bank or page not tracking the counter");

  property p_operand_mem;
    ##1 $past(instr_r[3:2]) == 2'b10
      |-> operand_r.sel == cpu_decode_pkg::SEL_MEM_ONE
      && operand_r.addr == $past(index_ptr_one);
  endproperty
  a_operand_mem: assert property (p_operand_mem) // RULE1
    else $error("memory operand not at first index pointer");

  property p_direct_range;
    direct_addr[11:4] == 8'h00 ##1 direct_addr[3:0] == $past(instr_r[3:0]);
  endproperty
  a_direct_range: assert property (p_direct_range) // RULE4
    else $error("direct operand outside first sixteen locations");

  property p_dec_add;
    alu_go && !alu_sub && flags_r.decimal && alu_a <= 4'h9 && alu_b <= 4'h9
      |=> alu_res <= 4'h9;
  endproperty
  a_dec_add: assert property (p_dec_add) // RULE7
    else $error("decimal add left a non-decimal digit");

  property p_stack_addr;
    ##1 stack_addr == {4'h0, $past(stack_ptr)};
  endproperty
  a_stack_addr: assert property (p_stack_addr) // RULE3
    else $error("stack operand address does not follow pointer");

endmodule

// ### verif/prog_mem_model.sv
// Program memory model that hands the core one instruction word per fetch.
// Assumes the core takes a word on a rising edge with valid and ready high.
`timescale 1ns/10ps
module prog_mem_model (
  // Clock.
  input wire logic clk_sys,
  // Fetch side.
  input wire cpu_decode_pkg::pc_t instr_addr,
  input wire logic instr_ready,
  output logic [11:0] instr_word,
  output logic instr_valid,
  // Bench control: offer a word once lag idle cycles have passed.
  input wire logic serve,
  input wire logic [2:0] lag
);
  logic [11:0] mem [0:8191];
  logic [11:0] last_word;
  logic [2:0] wait_cnt;

  //////////////////////////////////////////
  // Preload one word; the bench calls this before each fetch.
  task automatic load(input logic [12:0] a, input logic [11:0] w);
    mem[a] = w;
  endtask

  // Off the valid window the lines show the inverse, so stale data never
  // passes for a fresh word.
  assign instr_word = instr_valid ? mem[instr_addr] : ~last_word;

  // Valid rises off the sampling edge and stands until the core takes it.
  always @(negedge clk_sys) begin
    if (!serve || !instr_ready) begin
      instr_valid <= 1'b0;
      wait_cnt <= 3'h0;
    end else if (wait_cnt >= lag) begin
      instr_valid <= 1'b1;
    end else begin
      wait_cnt <= wait_cnt + 3'h1;
    end
  end

  // Remember the last word handed over.
  always @(posedge clk_sys) begin
    if (instr_valid && instr_ready) last_word <= instr_word;
  end

  initial begin
    instr_valid = 1'b0;
    wait_cnt = 3'h0;
    last_word = 12'h000;
  end
endmodule

// ### verif/cpu_operand_and_bank_set_decode_tb.sv
// Self-checking bench for the operand and bank decode core.
// Assumes the program memory model serves every fetch the bench asks for.
`timescale 1ns/10ps
module cpu_operand_and_bank_set_decode_tb;
  logic clk_sys, nrst, instr_valid, instr_ready, instr_done, wr_en;
  logic alu_go, alu_sub, alu_use_carry, pending_bank, serve, cy, exp_bank;
  logic [11:0] instr_word, direct_addr, stack_addr;
  logic [3:0] wr_data, flag_set, flag_clr, alu_a, alu_b, alu_res;
  logic [3:0] pending_page, pc_step_high, pc_step_low, exp_page;
  logic [7:0] stack_ptr;
  logic [2:0] lag;
  int error_cnt, samples_checked;
  cpu_decode_pkg::pc_t instr_addr, exp_pc;
  cpu_decode_pkg::nibble_tgt_t wr_tgt;
  cpu_decode_pkg::index_t index_ptr_one, index_ptr_two;
  cpu_decode_pkg::flags_t flags;
  cpu_decode_pkg::operand_t operand_r, operand_q;

  cpu_operand_and_bank_set_decode cpu_operand_and_bank_set_decode_i (
    .clk_sys, .nrst, .instr_addr, .instr_word, .instr_valid, .instr_ready,
    .instr_done, .wr_en, .wr_tgt, .wr_data, .flag_set, .flag_clr, .alu_go,
    .alu_sub, .alu_use_carry, .alu_a, .alu_b, .alu_res, .index_ptr_one,
    .index_ptr_two, .stack_ptr, .flags, .pending_bank, .pending_page,
    .pc_step_high, .pc_step_low, .operand_r, .operand_q, .direct_addr,
    .stack_addr);
  prog_mem_model prog_mem_model_i (.clk_sys, .instr_addr, .instr_ready,
    .instr_word, .instr_valid, .serve, .lag);

  //////////////////////////////////////////
  // Free-running 25 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  // Compare one value and count it.
  task automatic check(input string what, input logic [31:0] got,
                       input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Report the counts and the verdict, then stop.
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // A wait that ran out of its bound ends the run as a mismatch.
  task automatic hang();
    error_cnt++;
    $display("[FAIL] fetch expected done seen timeout");
    conclude();
  endtask

  // Fetch one word through the model, time it and predict the counter.
  task automatic run_instr(input logic [11:0] w, input logic [2:0] l);
    int n;
    int done_n;
    logic jmp;
    n = 0;
    done_n = 0;
    lag = l;
    prog_mem_model_i.load(instr_addr, w);
    serve = 1'b1;
    while (instr_ready === 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 20) hang();
    end
    serve = 1'b0;
    n = 0;
    while (instr_ready !== 1'b1) begin
      if (instr_done === 1'b1) done_n++;
      @(negedge clk_sys);
      n++;
      if (n > 20) hang();
    end
    check("busy", n, cpu_decode_pkg::CLK_PER_INSTR - 1);
    check("done_pulses", done_n, 1);
    jmp = w[11:8] == cpu_decode_pkg::OPC_JUMP ||
          (w[11:8] == cpu_decode_pkg::OPC_JUMP_C && cy) ||
          (w[11:8] == cpu_decode_pkg::OPC_JUMP_NC && !cy);
    if (w[11:5] == cpu_decode_pkg::OPC_PRESET) begin
      {exp_bank, exp_page} = w[4:0];
      exp_pc.step = exp_pc.step + 8'h01;
    end else begin
      if (jmp) exp_pc = {exp_bank, exp_page, w[7:0]};
      else exp_pc.step = exp_pc.step + 8'h01;
      {exp_bank, exp_page} = {exp_pc.bank, exp_pc.page};
    end
    check("pc", instr_addr, exp_pc);
    check("step", {pc_step_high, pc_step_low}, exp_pc.step);
    check("pend", {pending_bank, pending_page},
          {exp_bank, exp_page});
  endtask

  // One-cycle nibble write.
  task automatic wr(input cpu_decode_pkg::nibble_tgt_t t,
                    input logic [3:0] d);
    wr_en = 1'b1;
    wr_tgt = t;
    wr_data = d;
    @(negedge clk_sys);
    wr_en = 1'b0;
  endtask

  // One-cycle flag set and clear.
  task automatic setf(input logic [3:0] s, input logic [3:0] c);
    flag_set = s;
    flag_clr = c;
    @(negedge clk_sys);
    flag_set = 4'h0;
    flag_clr = 4'h0;
  endtask

  // One arithmetic step; exp holds carry over the result nibble.
  task automatic alu(input logic [3:0] a, input logic [3:0] b,
                     input logic sub, input logic [4:0] exp);
    alu_go = 1'b1;
    alu_a = a;
    alu_b = b;
    alu_sub = sub;
    @(negedge clk_sys);
    alu_go = 1'b0;
    check("alu", {flags.zero, alu_res, flags.carry},
          {exp[3:0] == 4'h0, exp[3:0], exp[4]});
  endtask

  // Pointer value that an operand code addresses.
  function automatic logic [11:0] sel_addr(input int c);
    return c == 2 ? 12'hB89 : (c == 3 ? 12'hEFC : 12'h000);
  endfunction

  //////////////////////////////////////////
  // Main sequence.
  initial begin
    {nrst, wr_en, alu_go, alu_sub, alu_use_carry, serve, cy} = 7'h00;
    {wr_data, flag_set, flag_clr, alu_a, alu_b} = 20'h0_0000;
    {lag, exp_bank, exp_page, exp_pc} = '0;
    wr_tgt = cpu_decode_pkg::TGT_NONE;
    error_cnt = 0;
    samples_checked = 0;
    repeat (10) @(negedge clk_sys);
    nrst = 1'b1;
    repeat (3) @(negedge clk_sys);
    check("rst", {instr_addr, pending_bank, pending_page, flags, stack_ptr},
          32'h0000_0000);
    check("rst_idx", {index_ptr_one, index_ptr_two}, 32'h0000_0000);
    check("rst_hs", {instr_ready, instr_done}, 2'b10);
    $display("test reset done");
    for (int t = 1; t < 9; t++) begin
      wr(cpu_decode_pkg::nibble_tgt_t'(t), 4'(t) ^ 4'hA);
    end
    wr(cpu_decode_pkg::TGT_NONE, 4'h5);
    @(negedge clk_sys);
    check("index_one", index_ptr_one, 12'hB89);
    check("index_two", index_ptr_two, 12'hEFC);
    check("stack", stack_ptr, 8'hD2);
    check("stack_addr", stack_addr, 12'h0D2);
    $display("test nibbles done");
    for (int c = 0; c < 4; c++) begin
      run_instr({8'h45, 2'(c), 2'(3 - c)}, 3'(c));
      check("opnd_r", operand_r, {2'(c), sel_addr(c)});
      check("opnd_q", operand_q, {2'(3 - c), sel_addr(3 - c)});
      check("direct", direct_addr, {8'h00, 2'(c), 2'(3 - c)});
    end
    $display("test operands done");
    setf(4'hF, 4'h0);
    check("flags_set", flags, 4'hF);
    for (int i = 0; i < 4; i++) begin
      setf(4'h0, 4'h1 << i);
      check("flags_clr", flags, 4'(4'hF << (i + 1)));
    end
    setf(4'h1, 4'h1);
    check("set_wins", flags, 4'h1);
    setf(4'h0, 4'hF);
    $display("test flags done");
    alu(4'h7, 4'h5, 1'b0, 5'h0C);
    alu(4'h9, 4'h8, 1'b0, 5'h11);
    alu(4'h8, 4'h8, 1'b0, 5'h10);
    alu(4'h3, 4'h5, 1'b1, 5'h1E);
    // The borrow left by the subtract feeds the next add as carry in.
    alu_use_carry = 1'b1;
    alu(4'h7, 4'h5, 1'b0, 5'h0D);
    alu_use_carry = 1'b0;
    setf(4'h4, 4'h0);
    alu(4'h7, 4'h5, 1'b0, 5'h12);
    alu(4'h4, 4'h5, 1'b0, 5'h09);
    alu(4'h9, 4'h9, 1'b0, 5'h18);
    alu(4'h3, 4'h5, 1'b1, 5'h18);
    alu(4'h9, 4'h4, 1'b1, 5'h05);
    setf(4'h0, 4'hF);
    $display("test arithmetic done");
    run_instr(12'hE40, 3'h0);
    run_instr(12'hE5F, 3'h2);
    run_instr(12'hE55, 3'h0);
    run_instr(12'h0FF, 3'h1);
    run_instr(12'h400, 3'h0);
    run_instr(12'h0A7, 3'h0);
    run_instr(12'h210, 3'h0);
    run_instr(12'h330, 3'h0);
    setf(4'h1, 4'h0);
    cy = 1'b1;
    run_instr(12'h212, 3'h0);
    run_instr(12'hE4A, 3'h0);
    run_instr(12'h320, 3'h0);
    $display("test branches done");
    conclude();
  end
endmodule
